// *** lsf_pkg.sv ***
// Purpose: Constants for the LIN status flag register bank.
// Assumes: Eight-bit indirect register port, 100 MHz controller clock.
// Notes: Field positions, offsets and timing counts are defined here; the assertions and bench repeat some as literals.
package lsf_pkg;
	localparam logic [3:0] lsf_ctrl_addr = 4'h8;
	localparam logic [3:0] lsf_stat_addr = 4'h9;
	localparam int lsf_bit_active = 7;
	localparam int lsf_bit_idle = 6;
	localparam int lsf_bit_abort = 5;
	localparam int lsf_bit_dreq = 4;
	localparam int lsf_bit_int = 3;
	localparam int lsf_bit_err = 2;
	localparam int lsf_bit_wake = 1;
	localparam int lsf_bit_done = 0;
	localparam int lsf_ctl_halt = 7;
	localparam int lsf_ctl_int_reset = 3;
	localparam int lsf_ctl_err_reset = 2;
	localparam logic [7:0] lsf_stat_reset = 8'h00;
	localparam int lsf_idle_time_s = 4;
	localparam int lsf_clk_hz = 100000000;
	localparam longint lsf_idle_cycles = longint'(lsf_idle_time_s) * lsf_clk_hz;
endpackage : lsf_pkg

// *** lsf_status.sv ***
// Purpose: LIN status flag register, read through the indirect register port.
// Assumes: Event strobes come from logic on clk; bus activity comes from the pin.
// Notes: Status register is read-only; control strobes are write-one pulses.
module lsf_status #(
	parameter longint idle_cycles = lsf_pkg::lsf_idle_cycles
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Indirect register port.
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Mode and bus pin.
	input wire logic slave_mode,
	input wire logic bus_sleep,
	input wire logic lin_rx_pin,
	// Frame engine event strobes.
	input wire logic break_seen,
	input wire logic id_received,
	input wire logic frame_end,
	input wire logic tx_start,
	input wire logic tx_done,
	input wire logic int_event,
	input wire logic err_event,
	input wire logic wake_tx_active,
	input wire logic wake_rx,
	input wire logic wake_clear,
	// Outputs to neighbouring logic.
	output logic error_reset_strobe,
	output logic processing_halted
);
	// The idle counter is 32 bits wide; a longer timeout could never be reached.
	if (idle_cycles < 2 || idle_cycles > longint'(32'hffff_ffff))
	begin : idle_range_check
		$error("idle_cycles out of range");
	end

	logic [7:0] lin_status_q;
	logic rx_s1_q, rx_s2_q, rx_s3_q;
	logic [31:0] idle_cnt_q;
	logic in_frame_q;
	logic ctl_wr, int_reset_wr, err_reset_wr, halt;
	logic wake_rx_q;

	// Control strobes are pulses; no register keeps the written byte, so the control address reads as zero.
	assign ctl_wr = reg_wr && (reg_addr == lsf_pkg::lsf_ctrl_addr);
	assign int_reset_wr = ctl_wr && reg_wdata[lsf_pkg::lsf_ctl_int_reset];
	assign err_reset_wr = ctl_wr && reg_wdata[lsf_pkg::lsf_ctl_err_reset];
	assign halt = ctl_wr && reg_wdata[lsf_pkg::lsf_ctl_halt] && slave_mode;

	// Pin synchroniser; a mismatch between the second and third stages marks activity.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
		end
		else
		begin
			rx_s1_q <= lin_rx_pin;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
		end
	end

	// Idle counter restarts on any bus edge; saturates at the timeout.
	always_ff @(posedge clk)
	begin
		if (rst || rx_s2_q != rx_s3_q)
		begin
			idle_cnt_q <= 32'h0000_0000;
		end
		else if (longint'(idle_cnt_q) < idle_cycles)
		begin
			idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
		end
	end

	// Frame tracking: a break starts a frame, the frame end closes it.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			in_frame_q <= 1'b0;
			processing_halted <= 1'b0;
		end
		else
		begin
			if (break_seen)
				in_frame_q <= 1'b1;
			else if (frame_end)
				in_frame_q <= 1'b0;
			if (halt)
				processing_halted <= 1'b1;
			else if (break_seen)
				processing_halted <= 1'b0;
		end
	end

	// A received wakeup is remembered until cleared; a sent one shows only while sending.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wake_rx_q <= 1'b0;
		end
		else if (wake_rx)
		begin
			wake_rx_q <= 1'b1;
		end
		else if (wake_clear)
		begin
			wake_rx_q <= 1'b0;
		end
	end

	// Status flags. Sets win over clears so no event is lost.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lin_status_q <= lsf_pkg::lsf_stat_reset;
		end
		else
		begin
			// The edge itself, not the idle count, so a reset cannot fake activity.
			lin_status_q[lsf_pkg::lsf_bit_active] <= (rx_s2_q != rx_s3_q);
			lin_status_q[lsf_pkg::lsf_bit_idle] <= slave_mode && !bus_sleep
				&& (longint'(idle_cnt_q) >= idle_cycles);
			if (slave_mode && ((break_seen && in_frame_q) || halt))
				lin_status_q[lsf_pkg::lsf_bit_abort] <= 1'b1;
			else if (break_seen)
				lin_status_q[lsf_pkg::lsf_bit_abort] <= 1'b0;
			if (slave_mode && id_received)
				lin_status_q[lsf_pkg::lsf_bit_dreq] <= 1'b1;
			else if (!slave_mode || break_seen || frame_end)
				lin_status_q[lsf_pkg::lsf_bit_dreq] <= 1'b0;
			if (int_event)
				lin_status_q[lsf_pkg::lsf_bit_int] <= 1'b1;
			else if (int_reset_wr)
				lin_status_q[lsf_pkg::lsf_bit_int] <= 1'b0;
			if (err_event)
				lin_status_q[lsf_pkg::lsf_bit_err] <= 1'b1;
			else if (err_reset_wr)
				lin_status_q[lsf_pkg::lsf_bit_err] <= 1'b0;
			lin_status_q[lsf_pkg::lsf_bit_wake] <= wake_tx_active || wake_rx
				|| (wake_rx_q && !wake_clear);
			if (tx_done)
				lin_status_q[lsf_pkg::lsf_bit_done] <= 1'b1;
			else if (tx_start)
				lin_status_q[lsf_pkg::lsf_bit_done] <= 1'b0;
		end
	end

	// Read data and error-reset strobe, both registered.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata <= 8'h00;
			error_reset_strobe <= 1'b0;
		end
		else
		begin
			reg_rdata <= (reg_addr == lsf_pkg::lsf_stat_addr) ? lin_status_q : 8'h00;
			error_reset_strobe <= err_reset_wr;
		end
	end

	int_clr_a: assert property (@(posedge clk) disable iff (rst)
		int_reset_wr && !int_event |=> !lin_status_q[3]) else $error("int not cleared");
	int_hold_a: assert property (@(posedge clk) disable iff (rst)
		lin_status_q[3] && !int_reset_wr |=> lin_status_q[3]) else $error("int lost");
	err_set_a: assert property (@(posedge clk) disable iff (rst)
		err_event |=> lin_status_q[2]) else $error("err not set");
	err_hold_a: assert property (@(posedge clk) disable iff (rst)
		lin_status_q[2] && !err_reset_wr |=> lin_status_q[2]) else $error("err lost");
	errrst_pulse_a: assert property (@(posedge clk) disable iff (rst)
		err_reset_wr |=> error_reset_strobe) else $error("no err strobe");
	done_start_a: assert property (@(posedge clk) disable iff (rst)
		tx_start && !tx_done |=> !lin_status_q[0]) else $error("done kept");
	done_set_a: assert property (@(posedge clk) disable iff (rst)
		tx_done |=> lin_status_q[0]) else $error("done not set");
	abort_halt_a: assert property (@(posedge clk) disable iff (rst)
		halt |=> lin_status_q[5] && processing_halted) else $error("halt lost");
	abort_clr_a: assert property (@(posedge clk) disable iff (rst)
		break_seen && !in_frame_q && !halt |=> !lin_status_q[5]) else $error("abort kept");
	dreq_set_a: assert property (@(posedge clk) disable iff (rst)
		slave_mode && id_received |=> lin_status_q[4]) else $error("dreq not set");
	wake_set_a: assert property (@(posedge clk) disable iff (rst)
		wake_rx |=> lin_status_q[1]) else $error("wake not set");
	write_ro_a: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == 4'h9 && !int_event && !err_event
		|=> lin_status_q[3:2] == $past(lin_status_q[3:2])) else $error("ro changed");
	ctl_zero_a: assert property (@(posedge clk) disable iff (rst)
		reg_addr == 4'h8 |=> reg_rdata == 8'h00) else $error("ctrl not zero");
	active_edge_a: assert property (@(posedge clk) disable iff (rst)
		$changed(rx_s2_q) |=> lin_status_q[7]) else $error("activity missed");
	active_quiet_a: assert property (@(posedge clk) disable iff (rst)
		$stable(rx_s2_q) |=> !lin_status_q[7]) else $error("false activity");
	idle_mode_a: assert property (@(posedge clk) disable iff (rst)
		!slave_mode || bus_sleep |=> !lin_status_q[6]) else $error("idle flag wrongly set");
	wake_tx_a: assert property (@(posedge clk) disable iff (rst)
		wake_tx_active |=> lin_status_q[1]) else $error("wake send not shown");

	int_cycle_c: cover property (@(posedge clk) int_event ##[1:20] int_reset_wr);
	idle_timeout_c: cover property (@(posedge clk) slave_mode && lin_status_q[6]);
	abort_brk_c: cover property (@(posedge clk) in_frame_q && break_seen);
	done_cycle_c: cover property (@(posedge clk) tx_start ##[1:50] tx_done);
endmodule : lsf_status

// *** lsf_bus_node.sv ***
// Purpose: Far LIN node that moves the bus pin during one frame on request.
// Assumes: The bus idles recessive high through its pull-up.
// Notes: The pin stands still outside frames, as a real node leaves it.
module lsf_bus_node (
	// Clock and request.
	input wire logic clk,
	input wire logic go,
	// Bus pin.
	output logic rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// Edges land off the clock edge, since the pin is asynchronous to the block.
	initial
	begin
		rx = 1'b1;
		forever
		begin
			@(posedge go);
			repeat (12)
			begin
				repeat (7) @(posedge clk);
				#3 rx = ~rx;
			end
			rx = 1'b1;
		end
	end
endmodule : lsf_bus_node

// *** lsf_status_test.sv ***
// Purpose: Self-checking bench for the LIN status flag register.
// Assumes: Idle count shortened to 50 cycles; status read with address held at 0x9.
// Notes: Rows cover the event flags; reset, idle and activity are hand tests.
module lsf_status_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [9:0] ev; logic [3:0] wa; logic [7:0] wd; logic [7:0] ex;} lsf_row_type;
	localparam int nrows = 24;
	logic clk, rst, reg_wr, slave_mode, bus_sleep, go, rx, error_reset_strobe, processing_halted;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [9:0] ev;
	int mismatches = 0;
	int comparisons = 0;
	int i;
	logic strobe_exp;
	lsf_row_type rows [nrows];
	// Far node drives the pin; event bits map to the frame engine strobes.
	lsf_bus_node far_node (.clk(clk), .go(go), .rx(rx));
	lsf_status #(.idle_cycles(50)) uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slave_mode(slave_mode),
		.bus_sleep(bus_sleep), .lin_rx_pin(rx), .break_seen(ev[0]), .id_received(ev[1]),
		.frame_end(ev[2]), .tx_start(ev[3]), .tx_done(ev[4]), .int_event(ev[5]),
		.err_event(ev[6]), .wake_rx(ev[7]), .wake_clear(ev[8]), .wake_tx_active(ev[9]),
		.error_reset_strobe(error_reset_strobe), .processing_halted(processing_halted));
	// Free-running 100 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compares one status byte and counts the outcome.
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk
	// Single exit point for every path, including exhausted waits.
	task automatic test_done;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Rows: event bits, write address (0 for none), write data, expected status.
	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_addr = 4'h9;
		reg_wdata = 8'h00;
		slave_mode = 1'b1;
		bus_sleep = 1'b1;
		go = 1'b0;
		ev = 10'h000;
		rows = '{{10'h020, 4'h0, 8'h00, 8'h08}, {10'h040, 4'h0, 8'h00, 8'h0c},
			{10'h000, 4'h8, 8'h08, 8'h04}, {10'h000, 4'h8, 8'h04, 8'h00},
			{10'h008, 4'h0, 8'h00, 8'h00}, {10'h010, 4'h0, 8'h00, 8'h01},
			{10'h008, 4'h0, 8'h00, 8'h00}, {10'h080, 4'h0, 8'h00, 8'h02},
			{10'h100, 4'h0, 8'h00, 8'h00}, {10'h200, 4'h0, 8'h00, 8'h02},
			{10'h000, 4'h0, 8'h00, 8'h00}, {10'h001, 4'h0, 8'h00, 8'h00},
			{10'h001, 4'h0, 8'h00, 8'h20}, {10'h002, 4'h0, 8'h00, 8'h30},
			{10'h004, 4'h0, 8'h00, 8'h20}, {10'h001, 4'h0, 8'h00, 8'h00},
			{10'h004, 4'h0, 8'h00, 8'h00}, {10'h000, 4'h8, 8'h80, 8'h20},
			{10'h001, 4'h0, 8'h00, 8'h00}, {10'h004, 4'h0, 8'h00, 8'h00},
			{10'h020, 4'h0, 8'h00, 8'h08}, {10'h000, 4'h9, 8'hff, 8'h08},
			{10'h000, 4'h8, 8'h00, 8'h08}, {10'h000, 4'h8, 8'h08, 8'h00}};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk(8'h00, reg_rdata);
		// Strobes last one cycle; the wakeup level stays until the next row.
		for (i = 0; i < nrows; i++)
		begin
			ev = rows[i].ev;
			reg_wr = (rows[i].wa != 4'h0);
			reg_addr = reg_wr ? rows[i].wa : 4'h9;
			reg_wdata = rows[i].wd;
			@(negedge clk);
			ev[8:0] = 9'h000;
			// The error-reset strobe stands for the one cycle after its write.
			strobe_exp = (rows[i].wa == 4'h8) && rows[i].wd[2];
			chk({7'h00, strobe_exp}, {7'h00, error_reset_strobe});
			reg_wr = 1'b0;
			reg_addr = 4'h9;
			repeat (3) @(negedge clk);
			chk(rows[i].ex, reg_rdata);
		end
		ev = 10'h000;
		// Sleep held the idle flag off so far; now let the short count run out.
		bus_sleep = 1'b0;
		repeat (80) @(negedge clk);
		chk(8'h40, reg_rdata);
		go = 1'b1;
		for (i = 0; i < 300 && reg_rdata[7] !== 1'b1; i++)
			@(negedge clk);
		chk(8'h80, {reg_rdata[7], 7'h00});
		if (i == 300)
			test_done();
		go = 1'b0;
		// Edges keep restarting the idle count, so the timeout flag stays off.
		repeat (30) @(negedge clk);
		chk(8'h00, {1'b0, reg_rdata[6], 6'h00});
		// Fifty quiet cycles have not yet passed since the last edge.
		repeat (70) @(negedge clk);
		chk(8'h00, {1'b0, reg_rdata[6], 6'h00});
		repeat (50) @(negedge clk);
		chk(8'h00, {reg_rdata[7], 7'h00});
		chk(8'h40, reg_rdata);
		// The control register always reads zero, even with a flag set.
		reg_addr = 4'h8;
		repeat (2) @(negedge clk);
		chk(8'h00, reg_rdata);
		// Outside slave mode the halt write and identifier strobe are refused.
		bus_sleep = 1'b1;
		slave_mode = 1'b0;
		reg_wr = 1'b1;
		reg_wdata = 8'h80;
		ev = 10'h002;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = 4'h9;
		ev = 10'h000;
		repeat (3) @(negedge clk);
		chk(8'h00, reg_rdata);
		chk(8'h00, {7'h00, processing_halted});
		// Back in slave mode the same halt write aborts and blocks processing.
		slave_mode = 1'b1;
		reg_wr = 1'b1;
		reg_addr = 4'h8;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = 4'h9;
		repeat (3) @(negedge clk);
		chk(8'h20, reg_rdata);
		chk(8'h01, {7'h00, processing_halted});
		// A second reset in mid-run must wipe every flag.
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk(8'h00, reg_rdata);
		chk(8'h00, {7'h00, processing_halted});
		test_done();
	end
endmodule : lsf_status_test
